// file: uncore_event_counter_bank.sv
`timescale 1ns/100ps
module uncore_event_counter_bank (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_msr_wr,
  input wire logic i_msr_rd,
  input wire logic [11:0] i_msr_addr,
  input wire logic [63:0] i_msr_wdata,
  input wire logic [3:0] i_snoop_valid,
  input wire logic [3:0] i_snoop_evict,
  input wire logic [3:0][2:0] i_snoop_result,
  input wire logic [3:0] i_lookup_valid,
  input wire logic [3:0] i_lookup_write,
  input wire logic [3:0][3:0] i_lookup_state,
  input wire logic [4:0] i_trk_occupancy,
  input wire logic i_trk_alloc,
  input wire logic i_trk_alloc_write,
  input wire logic i_coh_trk_alloc,
  output logic [63:0] o_msr_rdata,
  output logic o_msr_rd_valid,
  output logic o_monitor_interrupt,
  output logic o_tracker_overflow_flag
);

  // ------------------------------------------------------------
  // address decoding
  // ------------------------------------------------------------
  // index 0..7 are slice counters, 8 and 9 the tracker pair
  function automatic logic [11:0] unit_addr(input int idx, input logic is_count);
    logic [11:0] base;
    logic [11:0] slice;
    base = 12'h000;
    slice = 12'(idx / event_counter_pkg::UNIT_COUNTERS);
    if (idx >= event_counter_pkg::SLICE_UNITS * event_counter_pkg::UNIT_COUNTERS) begin
      base = is_count ? event_counter_pkg::ADDR_TRK_COUNT_BASE
                      : event_counter_pkg::ADDR_TRK_SELECT_BASE;
    end else begin
      base = (is_count ? event_counter_pkg::ADDR_SLICE_COUNT_BASE
                       : event_counter_pkg::ADDR_SLICE_SELECT_BASE)
             + slice * event_counter_pkg::ADDR_SLICE_STRIDE;
    end
    return base + 12'(idx % event_counter_pkg::UNIT_COUNTERS);
  endfunction

  // ------------------------------------------------------------
  // event sources
  // ------------------------------------------------------------
  function automatic logic [4:0] slice_incr(
    input logic [28:0] sel,
    input logic snp_valid,
    input logic snp_evict,
    input logic [2:0] snp_result,
    input logic lkp_valid,
    input logic lkp_write,
    input logic [3:0] lkp_state
  );
    logic [7:0] mask;
    logic [7:0] code;
    logic hit;
    mask = sel[event_counter_pkg::SUB_MASK_MSB:event_counter_pkg::SUB_MASK_LSB];
    code = sel[event_counter_pkg::CODE_MSB:0];
    hit = 1'b0;
    case (code)
      event_counter_pkg::CODE_SNOOP_RESPONSE: begin
        // mask bits: miss at 0, clean hit at 2, modified hit at 3 (result bits 0, 1, 2)
        hit = snp_valid
              && (snp_evict ? mask[event_counter_pkg::MASK_SNP_EVICT_BIT]
                            : mask[event_counter_pkg::MASK_SNP_CORE_BIT])
              && |({mask[3:2], mask[0]} & snp_result);
      end
      event_counter_pkg::CODE_CACHE_LOOKUP: begin
        hit = lkp_valid
              && (mask[event_counter_pkg::MASK_LKP_ANY_BIT]
                  || (lkp_write ? mask[event_counter_pkg::MASK_LKP_WRITE_BIT]
                                : mask[event_counter_pkg::MASK_LKP_READ_BIT]))
              && |(mask[3:0] & lkp_state);
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return {4'h0, hit};
  endfunction

  function automatic logic [4:0] tracker_incr(
    input logic [28:0] sel,
    input logic first_counter,
    input logic [4:0] occupancy,
    input logic alloc,
    input logic alloc_write,
    input logic coh_alloc
  );
    logic [7:0] mask;
    logic [7:0] code;
    logic [4:0] incr;
    mask = sel[event_counter_pkg::SUB_MASK_MSB:event_counter_pkg::SUB_MASK_LSB];
    code = sel[event_counter_pkg::CODE_MSB:0];
    incr = 5'h00;
    case (code)
      event_counter_pkg::CODE_TRK_OCCUPANCY: begin
        // occupancy is fed to counter 0 only; counter 1 sees nothing
        if (first_counter && mask[event_counter_pkg::MASK_ALL_BIT]) begin
          incr = occupancy;
        end
      end
      event_counter_pkg::CODE_TRK_REQUEST: begin
        incr = {4'h0, (mask[event_counter_pkg::MASK_ALL_BIT] && alloc)
                      || (mask[event_counter_pkg::MASK_TRK_WRITE_BIT] && alloc && alloc_write)};
      end
      event_counter_pkg::CODE_COH_TRK_REQUEST: begin
        incr = {4'h0, mask[event_counter_pkg::MASK_ALL_BIT] && coh_alloc};
      end
      default: begin
        incr = 5'h00;
      end
    endcase
    return incr;
  endfunction

  // ------------------------------------------------------------
  // counter units
  // ------------------------------------------------------------
  event_counter_pkg::bank_state_s state_q;
  event_counter_pkg::bank_state_s state_d;
  logic [event_counter_pkg::TOTAL_COUNTERS-1:0][28:0] unit_select;
  logic [event_counter_pkg::TOTAL_COUNTERS-1:0][43:0] unit_count;
  logic [event_counter_pkg::TOTAL_COUNTERS-1:0] unit_overflow;

  counter_link_if link[event_counter_pkg::TOTAL_COUNTERS]();

  genvar gi;
  generate
    for (gi = 0; gi < event_counter_pkg::TOTAL_COUNTERS; gi++) begin : g_unit
      localparam int SLICE = gi / event_counter_pkg::UNIT_COUNTERS;
      assign link[gi].wr_select = i_msr_wr && (i_msr_addr == unit_addr(gi, 1'b0));
      assign link[gi].wr_count = i_msr_wr && (i_msr_addr == unit_addr(gi, 1'b1));
      assign link[gi].wdata = i_msr_wdata;
      if (SLICE < event_counter_pkg::SLICE_UNITS) begin : g_slice
        assign link[gi].incr = slice_incr(link[gi].select, i_snoop_valid[SLICE],
                                          i_snoop_evict[SLICE], i_snoop_result[SLICE],
                                          i_lookup_valid[SLICE], i_lookup_write[SLICE],
                                          i_lookup_state[SLICE]);
      end else begin : g_tracker
        assign link[gi].incr = tracker_incr(link[gi].select,
                                            (gi % event_counter_pkg::UNIT_COUNTERS) == 0,
                                            i_trk_occupancy, i_trk_alloc,
                                            i_trk_alloc_write, i_coh_trk_alloc);
      end
      assign unit_select[gi] = link[gi].select;
      assign unit_count[gi] = link[gi].count;
      assign unit_overflow[gi] = link[gi].overflow;
      event_counter_unit u_unit (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_global_enable(state_q.global_enable),
        .link(link[gi])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // register access and global state
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    state_d.rd_valid = i_msr_rd;
    state_d.monitor_interrupt = 1'b0;
    for (int k = 0; k < event_counter_pkg::TOTAL_COUNTERS; k++) begin
      if (unit_overflow[k] && unit_select[k][event_counter_pkg::OVERFLOW_FORWARD_BIT]) begin
        state_d.monitor_interrupt = 1'b1;
      end
    end
    if (i_msr_wr && (i_msr_addr == event_counter_pkg::ADDR_GLOBAL_CTRL)) begin
      state_d.global_enable = i_msr_wdata[event_counter_pkg::GLOBAL_ENABLE_BIT];
    end
    // clear first so that an overflow in the same cycle still sets the flag
    if (i_msr_wr && (i_msr_addr == event_counter_pkg::ADDR_GLOBAL_STATUS)
        && i_msr_wdata[event_counter_pkg::TRK_OVERFLOW_BIT]) begin
      state_d.trk_overflow = 1'b0;
    end
    if (|unit_overflow[event_counter_pkg::TOTAL_COUNTERS-1:
                       event_counter_pkg::TOTAL_COUNTERS-event_counter_pkg::UNIT_COUNTERS]) begin
      state_d.trk_overflow = 1'b1;
    end
    if (i_msr_rd) begin
      state_d.rdata = 64'h0;
      if (i_msr_addr == event_counter_pkg::ADDR_SLICE_COUNT) begin
        state_d.rdata[event_counter_pkg::SLICE_COUNT_MSB:0] =
          event_counter_pkg::SLICE_COUNT_VALUE;
      end
      if (i_msr_addr == event_counter_pkg::ADDR_GLOBAL_CTRL) begin
        state_d.rdata[event_counter_pkg::GLOBAL_ENABLE_BIT] = state_q.global_enable;
      end
      if (i_msr_addr == event_counter_pkg::ADDR_GLOBAL_STATUS) begin
        state_d.rdata[event_counter_pkg::TRK_OVERFLOW_BIT] = state_q.trk_overflow;
      end
      for (int k = 0; k < event_counter_pkg::TOTAL_COUNTERS; k++) begin
        if (i_msr_addr == unit_addr(k, 1'b0)) begin
          state_d.rdata[28:0] = unit_select[k];
        end
        if (i_msr_addr == unit_addr(k, 1'b1)) begin
          state_d.rdata[43:0] = unit_count[k];
        end
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q.global_enable <= 1'b0;
      state_q.trk_overflow <= 1'b0;
      state_q.monitor_interrupt <= 1'b0;
      state_q.rd_valid <= 1'b0;
      state_q.rdata <= 64'h0;
    end else begin
      state_q <= state_d;
    end
  end

  assign o_msr_rdata = state_q.rdata;
  assign o_msr_rd_valid = state_q.rd_valid;
  assign o_monitor_interrupt = state_q.monitor_interrupt;
  assign o_tracker_overflow_flag = state_q.trk_overflow;

endmodule

// file: event_counter_pkg.sv
package event_counter_pkg;

  // ------------------------------------------------------------
  // register addresses
  // ------------------------------------------------------------
  localparam logic [11:0] ADDR_GLOBAL_CTRL = 12'he01;
  localparam logic [11:0] ADDR_GLOBAL_STATUS = 12'he02;
  localparam logic [11:0] ADDR_SLICE_COUNT = 12'h396;
  localparam logic [11:0] ADDR_TRK_COUNT_BASE = 12'h3b0;
  localparam logic [11:0] ADDR_TRK_SELECT_BASE = 12'h3b2;
  localparam logic [11:0] ADDR_SLICE_SELECT_BASE = 12'h700;
  localparam logic [11:0] ADDR_SLICE_COUNT_BASE = 12'h706;
  localparam logic [11:0] ADDR_SLICE_STRIDE = 12'h010;

  // ------------------------------------------------------------
  // sizes
  // ------------------------------------------------------------
  localparam int SLICE_UNITS = 4;
  localparam int UNIT_COUNTERS = 2;
  localparam int TOTAL_COUNTERS = (SLICE_UNITS + 1) * UNIT_COUNTERS;
  localparam int COUNT_WIDTH = 44;
  localparam int SELECT_WIDTH = 29;
  localparam int INCR_WIDTH = 5;

  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int GLOBAL_ENABLE_BIT = 29;
  localparam int TRK_OVERFLOW_BIT = 1;
  localparam int SLICE_COUNT_MSB = 3;
  localparam logic [3:0] SLICE_COUNT_VALUE = 4'h5;
  localparam int LEVEL_MSB = 28;
  localparam int LEVEL_LSB = 24;
  localparam int POLARITY_BIT = 23;
  localparam int LOCAL_ENABLE_BIT = 22;
  localparam int OVERFLOW_FORWARD_BIT = 20;
  localparam int EDGE_MODE_BIT = 18;
  localparam int SUB_MASK_MSB = 15;
  localparam int SUB_MASK_LSB = 8;
  localparam int CODE_MSB = 7;
  localparam logic [SELECT_WIDTH-1:0] SELECT_WRITE_MASK = 29'h1fd4ffff;
  localparam logic [SELECT_WIDTH-1:0] SELECT_RESET = 29'h0;
  localparam logic [COUNT_WIDTH-1:0] COUNT_RESET = 44'h0;

  // ------------------------------------------------------------
  // event codes and sub-event mask bits
  // ------------------------------------------------------------
  localparam logic [7:0] CODE_FABRIC_CYCLE = 8'h00;
  localparam logic [7:0] CODE_SNOOP_RESPONSE = 8'h22;
  localparam logic [7:0] CODE_CACHE_LOOKUP = 8'h34;
  localparam logic [7:0] CODE_TRK_OCCUPANCY = 8'h80;
  localparam logic [7:0] CODE_TRK_REQUEST = 8'h81;
  localparam logic [7:0] CODE_COH_TRK_REQUEST = 8'h84;
  localparam int MASK_ALL_BIT = 0;
  localparam int MASK_TRK_WRITE_BIT = 5;
  localparam int MASK_SNP_CORE_BIT = 6;
  localparam int MASK_SNP_EVICT_BIT = 7;
  localparam int MASK_LKP_READ_BIT = 4;
  localparam int MASK_LKP_WRITE_BIT = 5;
  localparam int MASK_LKP_ANY_BIT = 7;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [SELECT_WIDTH-1:0] select;
    logic [COUNT_WIDTH-1:0] count;
    logic prev_active;
    logic overflow;
  } unit_state_s;

  typedef struct packed {
    logic global_enable;
    logic trk_overflow;
    logic monitor_interrupt;
    logic rd_valid;
    logic [63:0] rdata;
  } bank_state_s;

endpackage

// file: counter_link_if.sv
`timescale 1ns/100ps
interface counter_link_if;
  logic wr_select;
  logic wr_count;
  logic [63:0] wdata;
  logic [event_counter_pkg::INCR_WIDTH-1:0] incr;
  logic [event_counter_pkg::SELECT_WIDTH-1:0] select;
  logic [event_counter_pkg::COUNT_WIDTH-1:0] count;
  logic overflow;

  modport unit (
    input wr_select,
    input wr_count,
    input wdata,
    input incr,
    output select,
    output count,
    output overflow
  );

  modport bank (
    output wr_select,
    output wr_count,
    output wdata,
    output incr,
    input select,
    input count,
    input overflow
  );
endinterface

// file: event_counter_unit.sv
`timescale 1ns/100ps
module event_counter_unit (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_global_enable,
  counter_link_if.unit link
);

  event_counter_pkg::unit_state_s state_q;
  event_counter_pkg::unit_state_s state_d;
  logic [4:0] level;
  logic [4:0] step;
  logic active;
  logic [44:0] sum;

  // ------------------------------------------------------------
  // compare and edge shaping
  // ------------------------------------------------------------
  assign level = state_q.select[event_counter_pkg::LEVEL_MSB:event_counter_pkg::LEVEL_LSB];

  always_comb begin
    if (level == 5'h00) begin
      step = link.incr;
    end else if (!state_q.select[event_counter_pkg::POLARITY_BIT]) begin
      step = (link.incr >= level) ? 5'h01 : 5'h00;
    end else begin
      step = (link.incr < level) ? 5'h01 : 5'h00;
    end
  end

  assign active = (step != 5'h00);

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    state_d.overflow = 1'b0;
    state_d.prev_active = active;
    sum = {1'b0, state_q.count};
    if (state_q.select[event_counter_pkg::LOCAL_ENABLE_BIT] && i_global_enable) begin
      if (state_q.select[event_counter_pkg::EDGE_MODE_BIT]) begin
        sum = {1'b0, state_q.count} + {44'h0, (active && !state_q.prev_active)};
      end else begin
        sum = {1'b0, state_q.count} + {40'h0, step};
      end
    end
    state_d.count = sum[43:0];
    state_d.overflow = sum[44];
    // a software write overrides the increment of the same cycle
    if (link.wr_count) begin
      state_d.count = link.wdata[43:0];
    end
    if (link.wr_select) begin
      state_d.select = link.wdata[28:0] & event_counter_pkg::SELECT_WRITE_MASK;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q.select <= event_counter_pkg::SELECT_RESET;
      state_q.count <= event_counter_pkg::COUNT_RESET;
      state_q.prev_active <= 1'b0;
      state_q.overflow <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  assign link.select = state_q.select;
  assign link.count = state_q.count;
  assign link.overflow = state_q.overflow;

endmodule

// file: event_source_model.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// event sources: slice 0 and the request tracker
// ------------------------------------------------------------
module event_source_model (
  input wire logic i_core_clk,
  input wire logic i_on,
  input wire logic i_gap,
  input wire logic [4:0] i_occ,
  output logic [3:0] o_snoop_valid,
  output logic [3:0] o_snoop_evict,
  output logic [3:0][2:0] o_snoop_result,
  output logic [3:0] o_lookup_valid,
  output logic [3:0] o_lookup_write,
  output logic [3:0][3:0] o_lookup_state,
  output logic [4:0] o_trk_occupancy,
  output logic o_trk_alloc,
  output logic o_trk_alloc_write,
  output logic o_coh_trk_alloc
);
  logic phase_q = 1'b0;
  logic act_q = 1'b0;
  // gap mode fires every other cycle so edge counting sees fresh rising steps
  always @(negedge i_core_clk) begin
    phase_q <= ~phase_q;
    act_q <= i_on & (~i_gap | ~phase_q);
  end
  // slice 0 only: misses and invalid-line lookups; origin and direction alternate
  // so that both halves of each mask decode are exercised
  assign o_snoop_valid = {3'h0, act_q};
  assign o_snoop_evict = {3'h0, act_q & phase_q};
  assign o_snoop_result = {9'h0, 3'h1};
  assign o_lookup_valid = {3'h0, act_q};
  assign o_lookup_write = {3'h0, act_q & phase_q};
  assign o_lookup_state = {12'h0, 4'h8};
  // occupancy is a level that holds between bursts, so windows count exactly
  assign o_trk_occupancy = i_occ;
  assign o_trk_alloc = act_q;
  // writes on alternate cycles: half of any even window
  assign o_trk_alloc_write = act_q & phase_q;
  assign o_coh_trk_alloc = act_q;
endmodule

// file: uncore_event_counter_bank_props.sv
`timescale 1ns/100ps
module event_counter_bank_props (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_msr_wr,
  input wire logic i_msr_rd,
  input wire logic [11:0] i_msr_addr,
  input wire logic [63:0] i_msr_wdata,
  input wire logic [63:0] o_msr_rdata,
  input wire logic o_msr_rd_valid,
  input wire logic o_monitor_interrupt,
  input wire logic o_tracker_overflow_flag
);
  localparam logic [11:0] STAT = event_counter_pkg::ADDR_GLOBAL_STATUS;
  localparam logic [11:0] CTRL = event_counter_pkg::ADDR_GLOBAL_CTRL;
  localparam logic [11:0] TS0 = event_counter_pkg::ADDR_TRK_SELECT_BASE;
  localparam logic [11:0] TC0 = event_counter_pkg::ADDR_TRK_COUNT_BASE;
  logic clr_req;
  logic [63:0] sel_keep;
  assign clr_req = i_msr_wr && i_msr_addr == STAT && i_msr_wdata[1];
  assign sel_keep = {35'h0, event_counter_pkg::SELECT_WRITE_MASK};
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);
  // ------------------------------------------------------------
  // read path and register contents
  // ------------------------------------------------------------
  property p_rd_valid;
    i_msr_rd |=> o_msr_rd_valid;
  endproperty
  a_rd_valid: assert property (p_rd_valid)
    else $error("read not answered");
  property p_rd_only;
    o_msr_rd_valid |-> $past(i_msr_rd);
  endproperty
  a_rd_only: assert property (p_rd_only)
    else $error("answer without read");
  property p_slice_count;
    i_msr_rd && i_msr_addr == event_counter_pkg::ADDR_SLICE_COUNT
      |=> o_msr_rdata == {60'h0, event_counter_pkg::SLICE_COUNT_VALUE};
  endproperty
  a_slice_count: assert property (p_slice_count)
    else $error("slice count wrong");
  property p_unmapped;
    i_msr_rd && i_msr_addr == 12'h000 |=> o_msr_rdata == 64'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_rdata_hold;
    !o_msr_rd_valid |-> $stable(o_msr_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without read");
  property p_flag_hold;
    o_tracker_overflow_flag && !clr_req |=> o_tracker_overflow_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("overflow flag dropped without clear");
  property p_status_read;
    i_msr_rd && i_msr_addr == STAT
      |=> o_msr_rdata == {62'h0, $past(o_tracker_overflow_flag), 1'b0};
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read wrong");
  property p_ctrl_read;
    i_msr_rd && i_msr_addr == CTRL
      |=> o_msr_rdata[63:30] == 34'h0 && o_msr_rdata[28:0] == 29'h0;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read)
    else $error("control read has stray bits");
  property p_sel_reserved;
    i_msr_rd && i_msr_addr == TS0 |=> (o_msr_rdata & ~sel_keep) == 64'h0;
  endproperty
  a_sel_reserved: assert property (p_sel_reserved)
    else $error("select reserved bits set");
  property p_cnt_reserved;
    i_msr_rd && i_msr_addr == TC0 |=> o_msr_rdata[63:44] == 20'h0;
  endproperty
  a_cnt_reserved: assert property (p_cnt_reserved)
    else $error("counter upper bits set");
  c_interrupt: cover property (o_monitor_interrupt);
  c_flag_set: cover property ($rose(o_tracker_overflow_flag));
  c_flag_clear: cover property (clr_req && o_tracker_overflow_flag);
endmodule
bind uncore_event_counter_bank event_counter_bank_props u_props (
  .i_core_clk(i_core_clk),
  .i_rst(i_rst),
  .i_msr_wr(i_msr_wr),
  .i_msr_rd(i_msr_rd),
  .i_msr_addr(i_msr_addr),
  .i_msr_wdata(i_msr_wdata),
  .o_msr_rdata(o_msr_rdata),
  .o_msr_rd_valid(o_msr_rd_valid),
  .o_monitor_interrupt(o_monitor_interrupt),
  .o_tracker_overflow_flag(o_tracker_overflow_flag)
);

// file: uncore_event_counter_bank_bench.sv
`timescale 1ns/100ps
module uncore_event_counter_bank_bench;
  localparam logic [11:0] CTRL = event_counter_pkg::ADDR_GLOBAL_CTRL;
  localparam logic [11:0] STAT = event_counter_pkg::ADDR_GLOBAL_STATUS;
  localparam logic [11:0] TS0 = event_counter_pkg::ADDR_TRK_SELECT_BASE;
  localparam logic [11:0] TC0 = event_counter_pkg::ADDR_TRK_COUNT_BASE;
  localparam logic [11:0] SS0 = event_counter_pkg::ADDR_SLICE_SELECT_BASE;
  localparam logic [11:0] SC0 = event_counter_pkg::ADDR_SLICE_COUNT_BASE;
  localparam logic [11:0] SLC = event_counter_pkg::ADDR_SLICE_COUNT;
  localparam logic [63:0] GEN = 64'h2000_0000;
  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_msr_wr = 1'b0;
  logic i_msr_rd = 1'b0;
  logic [11:0] i_msr_addr = 12'h000;
  logic [63:0] i_msr_wdata = 64'h0;
  logic ev_on = 1'b0;
  logic ev_gap = 1'b0;
  logic [4:0] ev_occ = 5'h00;
  logic [3:0] snp_v, snp_e, lkp_v, lkp_w;
  logic [3:0][2:0] snp_r;
  logic [3:0][3:0] lkp_s;
  logic [4:0] occ;
  logic alloc, alloc_wr, coh;
  logic [63:0] o_msr_rdata;
  logic o_msr_rd_valid, o_monitor_interrupt, o_tracker_overflow_flag;
  logic [63:0] rv;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int int_seen = 0;

  always #5 i_core_clk = ~i_core_clk;

  event_source_model src (.i_core_clk(i_core_clk), .i_on(ev_on), .i_gap(ev_gap),
    .i_occ(ev_occ), .o_snoop_valid(snp_v), .o_snoop_evict(snp_e), .o_snoop_result(snp_r),
    .o_lookup_valid(lkp_v), .o_lookup_write(lkp_w), .o_lookup_state(lkp_s),
    .o_trk_occupancy(occ), .o_trk_alloc(alloc), .o_trk_alloc_write(alloc_wr),
    .o_coh_trk_alloc(coh));

  uncore_event_counter_bank dut (.i_core_clk(i_core_clk), .i_rst(i_rst),
    .i_msr_wr(i_msr_wr), .i_msr_rd(i_msr_rd), .i_msr_addr(i_msr_addr),
    .i_msr_wdata(i_msr_wdata), .i_snoop_valid(snp_v), .i_snoop_evict(snp_e),
    .i_snoop_result(snp_r), .i_lookup_valid(lkp_v), .i_lookup_write(lkp_w),
    .i_lookup_state(lkp_s), .i_trk_occupancy(occ), .i_trk_alloc(alloc),
    .i_trk_alloc_write(alloc_wr), .i_coh_trk_alloc(coh), .o_msr_rdata(o_msr_rdata),
    .o_msr_rd_valid(o_msr_rd_valid), .o_monitor_interrupt(o_monitor_interrupt),
    .o_tracker_overflow_flag(o_tracker_overflow_flag));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task close_out;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task wr(input logic [11:0] a, input logic [63:0] d);
    @(negedge i_core_clk);
    i_msr_wr = 1'b1;
    i_msr_addr = a;
    i_msr_wdata = d;
    @(negedge i_core_clk);
    i_msr_wr = 1'b0;
  endtask

  task rd(input logic [11:0] a);
    @(negedge i_core_clk);
    i_msr_rd = 1'b1;
    i_msr_addr = a;
    @(negedge i_core_clk);
    i_msr_rd = 1'b0;
    rv = o_msr_rdata;
  endtask

  // enable window of exactly eight counting edges
  task win(input logic en);
    wr(CTRL, en ? GEN : 64'h0);
    repeat (6) @(negedge i_core_clk);
    wr(CTRL, 64'h0);
  endtask

  task run_case(input logic [11:0] sa, input logic [11:0] ca, input logic [63:0] sel,
                input logic gap, input logic en, input logic [63:0] exp);
    ev_gap <= gap;
    wr(sa, sel);
    wr(ca, 64'h0);
    win(en);
    rd(ca);
    check("count", rv, exp);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task t_regs;
    rd(SLC);
    check("slice_count", rv, {60'h0, event_counter_pkg::SLICE_COUNT_VALUE});
    wr(SLC, '1);
    rd(SLC);
    check("slice_count_ro", rv, {60'h0, event_counter_pkg::SLICE_COUNT_VALUE});
    check("slices", rv[3:0] - 4'h1, 4'(event_counter_pkg::SLICE_UNITS));
    rd(12'h000);
    check("unmapped", rv, 64'h0);
    wr(TS0, '1);
    rd(TS0);
    check("select", rv, {35'h0, event_counter_pkg::SELECT_WRITE_MASK});
    wr(TC0, '1);
    rd(TC0);
    check("counter", rv, {20'h0, 44'hfff_ffff_ffff});
    wr(CTRL, '1);
    rd(CTRL);
    check("ctrl", rv, GEN);
    wr(CTRL, 64'h0);
  endtask

  task t_overflow;
    wr(TS0, 64'h0050_0181);
    wr(TC0, 64'h0fff_ffff_fffe);
    int_seen = 0;
    win(1'b1);
    rd(TC0);
    check("wrap", rv, 64'h6);
    check("intr", 64'(int_seen), 64'h1);
    check("flag", o_tracker_overflow_flag, 1'b1);
    wr(STAT, 64'h0);
    check("flag_w0", o_tracker_overflow_flag, 1'b1);
    wr(STAT, 64'h2);
    check("flag_w1", o_tracker_overflow_flag, 1'b0);
    // counter 1 wraps with forwarding off: flag only, no interrupt
    wr(TS0, 64'h0);
    wr(TS0 + 12'h1, 64'h0040_0181);
    wr(TC0 + 12'h1, 64'h0fff_ffff_fffe);
    int_seen = 0;
    win(1'b1);
    check("no_intr", 64'(int_seen), 64'h0);
    check("flag1", o_tracker_overflow_flag, 1'b1);
  endtask

  // only slice 0 has events, so the total over all slices must equal its count
  task t_sum;
    logic [63:0] total;
    total = 64'h0;
    for (int s = 0; s < event_counter_pkg::SLICE_UNITS; s++) begin
      wr(SS0 + 12'(s) * event_counter_pkg::ADDR_SLICE_STRIDE, 64'h0040_8f34);
      wr(SC0 + 12'(s) * event_counter_pkg::ADDR_SLICE_STRIDE, 64'h0);
    end
    win(1'b1);
    for (int s = 0; s < event_counter_pkg::SLICE_UNITS; s++) begin
      rd(SC0 + 12'(s) * event_counter_pkg::ADDR_SLICE_STRIDE);
      total = total + rv;
    end
    check("slice_sum", total, 64'h8);
  endtask

  always @(posedge i_core_clk) begin
    if (o_monitor_interrupt === 1'b1) begin
      int_seen++;
    end
  end

  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      close_out;
    end
  end

  initial begin
    repeat (4) @(posedge i_core_clk);
    @(negedge i_core_clk);
    i_rst = 1'b0;
    t_regs;
    ev_on <= 1'b1;
    ev_occ <= 5'h03;
    wr(TS0 + 12'h1, 64'h0040_0180);
    wr(TC0 + 12'h1, 64'h0);
    run_case(TS0, TC0, 64'h0040_0181, 1'b0, 1'b1, 64'h8);
    run_case(TS0, TC0, 64'h0040_2081, 1'b0, 1'b1, 64'h4);
    run_case(TS0, TC0, 64'h0040_0184, 1'b0, 1'b1, 64'h8);
    run_case(TS0, TC0, 64'h0040_0180, 1'b0, 1'b1, 64'h18);
    run_case(TS0, TC0, 64'h0340_0180, 1'b0, 1'b1, 64'h8);
    run_case(TS0, TC0, 64'h0440_0180, 1'b0, 1'b1, 64'h0);
    run_case(TS0, TC0, 64'h04c0_0180, 1'b0, 1'b1, 64'h8);
    run_case(TS0, TC0, 64'h03c0_0180, 1'b0, 1'b1, 64'h0);
    run_case(TS0, TC0, 64'h0000_0181, 1'b0, 1'b1, 64'h0);
    run_case(TS0, TC0, 64'h0040_0181, 1'b0, 1'b0, 64'h0);
    run_case(TS0, TC0, 64'h0044_0184, 1'b0, 1'b1, 64'h0);
    run_case(TS0, TC0, 64'h0044_0184, 1'b1, 1'b1, 64'h4);
    run_case(TS0, TC0, 64'h0040_0184, 1'b1, 1'b1, 64'h4);
    run_case(TS0, TC0, 64'h0040_0100, 1'b0, 1'b1, 64'h0);
    run_case(SS0, SC0, 64'h0040_4122, 1'b0, 1'b1, 64'h4);
    run_case(SS0, SC0, 64'h0040_8122, 1'b0, 1'b1, 64'h4);
    run_case(SS0, SC0, 64'h0040_4422, 1'b0, 1'b1, 64'h0);
    run_case(SS0, SC0, 64'h0040_4822, 1'b0, 1'b1, 64'h0);
    run_case(SS0, SC0, 64'h0040_1834, 1'b0, 1'b1, 64'h4);
    run_case(SS0, SC0, 64'h0040_2834, 1'b0, 1'b1, 64'h4);
    run_case(SS0, SC0, 64'h0040_8f34, 1'b0, 1'b1, 64'h8);
    run_case(SS0, SC0, 64'h0040_8134, 1'b0, 1'b1, 64'h0);
    run_case(SS0, SC0, 64'h0040_1634, 1'b0, 1'b1, 64'h0);
    t_sum;
    rd(TC0 + 12'h1);
    check("occ_ctr1", rv, 64'h0);
    t_overflow;
    close_out;
  end
endmodule
